// ### logic/ett_pkg.sv
// Package for the event time-tag, time alignment and second pulse unit.
// Assumes a single 100 MHz system clock; the 20 ns tick is derived from it.
package ett_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned TICK_NS          = 20;
  localparam int unsigned TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned REF_HALF_NS      = 50;
  localparam int unsigned REF_HALF_CYCLES  = REF_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned EVENT_GAP_MS     = 5;
  localparam int unsigned MS_TICKS         = 1000000 / TICK_NS;
  localparam int unsigned SEC_MS           = 1000;
  localparam int unsigned HALF_MS_TICKS    = MS_TICKS / 2;
  localparam int unsigned PULSE_WIDTH_MS   = 5;
  localparam int unsigned BOOT_HIGH_MS     = 1;
  localparam int unsigned READY_MS         = 300;
  localparam int unsigned SETTLE_MS        = 2000;
  localparam int unsigned TICK_W           = 16;
  localparam int unsigned MS_W             = 10;
  localparam int unsigned SUB_W            = 16;
  localparam logic [SUB_W-1:0] SUB_RESET   = 16'h0000;
  localparam logic [MS_W-1:0]  MS_RESET    = 10'h000;
  localparam int unsigned REPORT_W         = 33;
  localparam int unsigned MEM_DEPTH        = 8;
  localparam int unsigned MEM_AW           = 3;
  typedef enum logic [1:0] {
    ETT_CAP_A,
    ETT_CAP_B
  } ett_src_t;
  typedef enum logic [1:0] {
    ETT_BOOT_HIGH,
    ETT_BOOT_HIZ,
    ETT_RUN
  } ett_boot_t;
endpackage

// ### logic/ett_report_mem.sv
// Small record store for capture reports, read data registered.
// Assumes the writer never overruns the reader by more than the depth.
`timescale 1ns/10ps
`default_nettype none
module ett_report_mem
  import ett_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                wr_en,
  input  wire logic [MEM_AW-1:0]   wr_addr,
  input  wire logic [REPORT_W-1:0] wr_data,
  input  wire logic [MEM_AW-1:0]   rd_addr,
  output logic      [REPORT_W-1:0] rd_data
);
  logic [REPORT_W-1:0] mem_q [MEM_DEPTH];
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule
`default_nettype wire

// ### logic/ett_top.sv
// Event time-tag, time alignment and second pulse unit.
// Inputs are synchronous to clock; the host reads reports through a pop strobe.
`timescale 1ns/10ps
`default_nettype none
module ett_top
  import ett_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_TICKS * TICK_CYCLES
)
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                capture_input_a,
  input  wire logic                capture_input_b,
  input  wire logic                polarity_a,
  input  wire logic                polarity_b,
  input  wire logic                time_alignment_mode,
  input  wire logic                alignment_source_b,
  input  wire logic                outside_frequency_mode,
  input  wire logic                ref_in,
  input  wire logic                pulse_polarity,
  input  wire logic [MS_W-1:0]     pulse_width_ms,
  input  wire logic [MS_W+2:0]     pulse_period_ms,
  input  wire logic                internal_timebase_align,
  input  wire logic                report_pop,
  output logic                     report_valid,
  output logic      [REPORT_W-1:0] report_data,
  output logic                     ref_out,
  output logic                     oscillator_enable,
  output logic                     drift_from_outside,
  output logic                     second_pulse_out,
  output logic                     second_pulse_out_en_n,
  output logic                     module_ready,
  output logic                     aligned,
  output logic      [MS_W-1:0]     ms_offset
);
  // Time-base millisecond follows MS_CYCLES, so a shortened millisecond scales both counters
  localparam int unsigned MS_TB_TICKS = MS_CYCLES / TICK_CYCLES;
  // Debug-visible reference selection
  logic ref_d, ref_q, ref_prev_q, tb_edge;
  logic [3:0] osc_cnt_d, osc_cnt_q;
  logic osc_d, osc_q;
  always_comb
  begin
    osc_cnt_d = (osc_cnt_q == 4'(REF_HALF_CYCLES - 1)) ? 4'h0 : osc_cnt_q + 4'h1;
    osc_d = (osc_cnt_q == 4'(REF_HALF_CYCLES - 1)) ? ~osc_q : osc_q;
    ref_d = outside_frequency_mode ? ref_in : osc_q;
    tb_edge = ref_q & ~ref_prev_q;
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      osc_cnt_q <= 4'h0;
      osc_q <= 1'b0;
      ref_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end
    else
    begin
      osc_cnt_q <= outside_frequency_mode ? 4'h0 : osc_cnt_d;
      osc_q <= outside_frequency_mode ? 1'b0 : osc_d;
      ref_q <= ref_d;
      ref_prev_q <= ref_q;
    end
  end
  assign oscillator_enable = ~outside_frequency_mode;
  assign ref_out = osc_q & ~outside_frequency_mode;
  assign drift_from_outside = outside_frequency_mode;

  // Time base: 20 ns ticks, milliseconds, seconds
  logic [TICK_W-1:0] tick_d, tick_q;
  logic [SUB_W-1:0] sub_d, sub_q;
  logic [MS_W-1:0] ms_d, ms_q;
  logic [31:0] free_d, free_q;
  logic [TICK_W-1:0] div_d, div_q;
  logic tick20, ms_wrap, sec_wrap;
  // Event edge detection; the synchroniser is assumed outside since inputs are synchronous
  logic [1:0] ev_in, ev_prev_q, ev_hit;
  logic sync_hit, first_q, first_d;
  logic [MS_W-1:0] koff_d, koff_q;
  assign ev_in = {capture_input_b ^ polarity_b, capture_input_a ^ polarity_a};
  always_comb
  begin
    ev_hit = ev_in & ~ev_prev_q;
    sync_hit = time_alignment_mode & ev_hit[alignment_source_b];
    div_d = (div_q == TICK_W'(TICK_CYCLES - 1)) ? '0 : div_q + 1'b1;
    tick20 = (div_q == TICK_W'(TICK_CYCLES - 1));
    free_d = tick20 ? free_q + 32'h0000_0001 : free_q;
    ms_wrap = tick20 && sub_q == SUB_W'(MS_TB_TICKS - 1);
    sec_wrap = ms_wrap && ms_q == MS_W'(SEC_MS - 1);
    sub_d = ms_wrap ? SUB_RESET : (tick20 ? sub_q + 1'b1 : sub_q);
    ms_d = ms_wrap ? (sec_wrap ? MS_RESET : ms_q + 1'b1) : ms_q;
    first_d = first_q;
    koff_d = koff_q;
    if (sync_hit && !first_q)
    begin
      // Realign at once: sub and ms clear at the clock edge after the event, so the lag is one clock
      first_d = 1'b1;
      sub_d = SUB_RESET;
      ms_d = MS_RESET;
      // Round the event's offset within the second to the nearest ms
      if (ms_q == MS_RESET && sub_q < SUB_W'(MS_TB_TICKS / 2))
        koff_d = MS_RESET;
      else if (sub_q >= SUB_W'(MS_TB_TICKS / 2))
        koff_d = (ms_q == MS_W'(SEC_MS - 1)) ? MS_RESET : ms_q + 1'b1;
      else
        koff_d = ms_q;
    end
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      div_q <= '0;
      free_q <= 32'h0000_0000;
      sub_q <= SUB_RESET;
      ms_q <= MS_RESET;
      ev_prev_q <= 2'h0;
      first_q <= 1'b0;
      koff_q <= MS_RESET;
    end
    else
    begin
      // Locked to the reference edge; the even reference period keeps ticks 20 ns apart
      div_q <= tb_edge ? '0 : div_d;
      free_q <= free_d;
      sub_q <= sub_d;
      ms_q <= ms_d;
      ev_prev_q <= ev_in;
      first_q <= time_alignment_mode ? first_d : 1'b0;
      koff_q <= koff_d;
    end
  end
  assign aligned = first_q;
  assign ms_offset = koff_q;

  // Capture reports, A kept and B dropped when both land together; B kept while A is the alignment source
  logic [MEM_AW:0] wp_d, wp_q, rp_d, rp_q;
  logic wr_en;
  logic stale_d, stale_q;
  logic [REPORT_W-1:0] wr_data;
  logic [MEM_AW-1:0] rd_addr;
  always_comb
  begin
    wr_en = 1'b0;
    wr_data = '0;
    for (int i = 0; i < 2; i++)
    begin
      if (ev_hit[i] && !(time_alignment_mode && alignment_source_b == i[0]) && !wr_en)
      begin
        wr_en = 1'b1;
        wr_data = {i[0], free_q};
      end
    end
    wp_d = wr_en ? wp_q + 1'b1 : wp_q;
    rp_d = (report_pop && report_valid) ? rp_q + 1'b1 : rp_q;
    rd_addr = rp_d[MEM_AW-1:0];
    // Read port returns the old word when it reads the slot being written
    stale_d = wr_en && (wp_q[MEM_AW-1:0] == rd_addr);
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wp_q <= '0;
      rp_q <= '0;
      stale_q <= 1'b0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      stale_q <= stale_d;
    end
  end
  // A fresh record into an empty store shows one cycle late, after its read settles
  assign report_valid = (wp_q != rp_q) && !stale_q;
  ett_report_mem u_mem
  (
    .clock   (clock),
    .wr_en   (wr_en),
    .wr_addr (wp_q[MEM_AW-1:0]),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (report_data)
  );

  // Second pulse with start-up sequence
  ett_boot_t boot_d, boot_q;
  logic [31:0] up_d, up_q, bms_d, bms_q;
  logic [MS_W+2:0] pms_d, pms_q;
  logic msp, pulse_on, rdy_d, rdy_q, out_d, out_q;
  always_comb
  begin
    up_d = (up_q == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : up_q + 32'h0000_0001;
    msp = internal_timebase_align ? ms_wrap : (up_q == 32'(MS_CYCLES - 1));
    bms_d = (msp && bms_q != 32'hFFFF_FFFF) ? bms_q + 32'h0000_0001 : bms_q;
    pms_d = msp ? ((pms_q >= pulse_period_ms - 1'b1) ? '0 : pms_q + 1'b1) : pms_q;
    if (internal_timebase_align && sec_wrap)
      pms_d = '0;
    pulse_on = ({3'h0, pulse_width_ms} > pms_q);
    rdy_d = rdy_q | (bms_q >= 32'(READY_MS));
    boot_d = boot_q;
    unique case (boot_q)
      ETT_BOOT_HIGH: if (bms_q >= 32'(BOOT_HIGH_MS)) boot_d = ETT_BOOT_HIZ;
      ETT_BOOT_HIZ: if (bms_q >= 32'(SETTLE_MS)) boot_d = ETT_RUN;
      ETT_RUN: boot_d = ETT_RUN;
    endcase
    out_d = (boot_q == ETT_BOOT_HIGH) ? 1'b1 : (pulse_on ^ ~pulse_polarity);
  end
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      up_q <= 32'h0000_0000;
      bms_q <= 32'h0000_0000;
      pms_q <= '0;
      rdy_q <= 1'b0;
      boot_q <= ETT_BOOT_HIGH;
      out_q <= 1'b1;
    end
    else
    begin
      up_q <= up_d;
      bms_q <= bms_d;
      pms_q <= pms_d;
      rdy_q <= rdy_d;
      boot_q <= boot_d;
      out_q <= out_d;
    end
  end
  assign second_pulse_out = out_q;
  assign second_pulse_out_en_n = (boot_q == ETT_BOOT_HIZ);
  assign module_ready = rdy_q;
endmodule
`default_nettype wire

// ### verif/ett_event_source.sv
// Model of the outside event sources feeding both capture inputs.
// Assumes the bench strobes fire at a falling edge and spaces them.
`timescale 1ns/10ps
`default_nettype none
module ett_event_source
(
  input  wire logic clock,
  input  wire logic fire_a,
  input  wire logic fire_b,
  input  wire logic pol_a,
  input  wire logic pol_b,
  output logic      line_a,
  output logic      line_b
);
  logic [1:0] hold_a = 2'h0;
  logic [1:0] hold_b = 2'h0;
  // Pulse outlives the strobe by three cycles, like a real slow source
  always @(posedge clock)
  begin
    hold_a <= fire_a ? 2'h3 : hold_a - 2'(hold_a != 2'h0);
    hold_b <= fire_b ? 2'h3 : hold_b - 2'(hold_b != 2'h0);
  end
  // Idle level follows polarity, so a polarity change alone is no event
  assign line_a = (fire_a || hold_a != 2'h0) ^ pol_a;
  assign line_b = (fire_b || hold_b != 2'h0) ^ pol_b;
endmodule
`default_nettype wire

// ### verif/ett_top_asserts.sv
// Port checks for the time-tag unit.
// Assumes one reset at start and MS_CYCLES equal to the design's.
`timescale 1ns/10ps
`default_nettype none
module ett_top_asserts
  import ett_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic capture_input_a,
  input wire logic polarity_a,
  input wire logic time_alignment_mode,
  input wire logic alignment_source_b,
  input wire logic outside_frequency_mode,
  input wire logic report_pop,
  input wire logic report_valid,
  input wire logic ref_out,
  input wire logic oscillator_enable,
  input wire logic drift_from_outside,
  input wire logic second_pulse_out,
  input wire logic second_pulse_out_en_n,
  input wire logic module_ready
);
  int unsigned cyc_q;
  int unsigned cyc_d;
  // Saturates so late start-up checks stay valid on long runs
  always_comb
    cyc_d = cyc_q + 32'(cyc_q < 32'h0FFF_FFFF);
  always_ff @(posedge clock or posedge reset)
    if (reset)
      cyc_q <= '0;
    else
      cyc_q <= cyc_d;
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  osc_follow_a: assert property (oscillator_enable == !outside_frequency_mode)
    else $error("oscillator enable wrong");
  drift_follow_a: assert property (drift_from_outside == outside_frequency_mode)
    else $error("drift source wrong");
  ref_quiet_a: assert property (outside_frequency_mode [*2] |-> !ref_out)
    else $error("reference output not quiet");
  ref_half_a: assert property (disable iff (reset || outside_frequency_mode)
    $rose(ref_out) |-> ref_out [*5] ##1 !ref_out) else $error("reference half period wrong");
  capture_a: assert property ($rose(capture_input_a) && !polarity_a
    && !(time_alignment_mode && !alignment_source_b) |-> ##2 report_valid) else $error("no report");
  report_hold_a: assert property (report_valid && !report_pop |=> report_valid)
    else $error("report dropped");
  ready_early_a: assert property (cyc_q < 290 * MS_CYCLES |-> !module_ready)
    else $error("ready too early");
  ready_late_a: assert property (cyc_q > 310 * MS_CYCLES |-> module_ready)
    else $error("ready too late");
  boot_high_a: assert property (cyc_q < 8 |-> second_pulse_out && !second_pulse_out_en_n)
    else $error("boot pulse missing");
  boot_hiz_a: assert property (cyc_q > 2 * MS_CYCLES && cyc_q < 1900 * MS_CYCLES |-> second_pulse_out_en_n)
    else $error("pulse output driven at boot");
  settle_a: assert property (cyc_q > 2100 * MS_CYCLES |-> !second_pulse_out_en_n)
    else $error("pulse output not driven");
endmodule
`default_nettype wire

// ### verif/ett_top_test.sv
// Self-checking bench for the time-tag unit and its event source model.
// Assumes a millisecond shortened to 10 clocks so start-up fits the run.
`timescale 1ns/10ps
`default_nettype none
module ett_top_test;
  import ett_pkg::*;
  localparam int unsigned MSC = 10;
  logic clock = 1'b0, reset = 1'b1, fa = 1'b0, fb = 1'b0, pa = 1'b0, pb = 1'b0, refi = 1'b0;
  logic tam = 1'b0, asb = 1'b0, ofm = 1'b0, ppol = 1'b1, itba = 1'b0, pop = 1'b0;
  logic [MS_W-1:0] pw = 10'h005;
  logic [MS_W+2:0] pp = 13'h0014;
  logic ca, cb, rv, ro, oe, dr, spo, spen, mr, al;
  logic [REPORT_W-1:0] rd;
  logic [MS_W-1:0] mso;
  logic [31:0] prev_c;
  int n_errors = 0, n_compared = 0, seed = 96, cyc = 0, prev_t = 0, n, m;
  int q_id[$], q_t[$];
  bit have_prev = 0;
  always #5 clock = ~clock;
  // Outside reference, off the system clock's edges
  initial #2 forever #50 refi = ~refi;
  always @(posedge clock) cyc <= cyc + 1;
  ett_event_source src (.clock(clock), .fire_a(fa), .fire_b(fb), .pol_a(pa), .pol_b(pb), .line_a(ca), .line_b(cb));
  ett_top #(.MS_CYCLES(MSC)) uut (.clock(clock), .reset(reset), .capture_input_a(ca), .capture_input_b(cb),
    .polarity_a(pa), .polarity_b(pb), .time_alignment_mode(tam), .alignment_source_b(asb),
    .outside_frequency_mode(ofm), .ref_in(refi), .pulse_polarity(ppol), .pulse_width_ms(pw),
    .pulse_period_ms(pp), .internal_timebase_align(itba), .report_pop(pop), .report_valid(rv),
    .report_data(rd), .ref_out(ro), .oscillator_enable(oe), .drift_from_outside(dr),
    .second_pulse_out(spo), .second_pulse_out_en_n(spen), .module_ready(mr), .aligned(al), .ms_offset(mso));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic fire(input logic a, input logic b, input int gap);
    int id;
    @(negedge clock);
    id = (a && !(tam && !asb)) ? 0 : (b && !(tam && asb)) ? 1 : -1;
    {fa, fb} = {a, b};
    if (id >= 0)
    begin
      q_id.push_back(id);
      q_t.push_back(cyc);
    end
    @(negedge clock);
    {fa, fb} = 2'b00;
    repeat (gap) @(negedge clock);
  endtask
  task automatic measure(input logic lvl, output int k);
    k = 0;
    while (spo === lvl && k < 1000)
    begin
      @(negedge clock);
      k++;
    end
  endtask
  task close_out;
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Model pops each record once and checks source and tick spacing
  always @(negedge clock)
  begin
    pop <= 1'b0;
    if (rv === 1'b1 && pop === 1'b0)
    begin
      if (q_id.size() == 0)
      begin
        q_id.push_back(2);
        q_t.push_back(0);
      end
      chk("report_src", {31'h0, rd[32]}, q_id[0]);
      if (have_prev)
        chk("tick_gap", rd[31:0] - prev_c, (q_t[0] - prev_t) / TICK_CYCLES);
      {prev_c, prev_t, have_prev} = {rd[31:0], q_t[0], 1'b1};
      void'(q_id.pop_front());
      void'(q_t.pop_front());
      pop <= 1'b1;
    end
  end
  initial
  begin
    repeat (6) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    chk("boot_drive", {spo, spen, mr}, 3'b100);
    while (cyc < 1000) @(negedge clock);
    chk("boot_hiz", spen, 1);
    while (cyc < 3200) @(negedge clock);
    chk("ready", mr, 1);
    for (int i = 0; i < 12; i++)
    begin
      {pa, pb} = 2'($random(seed));
      fire(i % 3 != 1, i % 3 != 0, 60 + 2 * ($unsigned($random(seed)) % 8));
    end
    ofm = 1'b1;
    repeat (20) @(negedge clock);
    chk("outside_mode", {oe, dr, ro}, 3'b010);
    ofm = 1'b0;
    repeat (20) @(negedge clock);
    chk("inside_mode", {oe, dr}, 2'b10);
    while (cyc < 20300) @(negedge clock);
    chk("settled", spen, 0);
    for (int j = 0; j < 2; j++)
    begin
      itba = j[0];
      repeat (2)
      begin
        measure(1'b1, n);
        measure(1'b0, m);
      end
      chk("pulse_high", n, pw * MSC);
      chk("pulse_low", m, (pp - pw) * MSC);
    end
    {tam, have_prev} = 2'b10;
    fire(1'b1, 1'b1, 60);
    chk("aligned", al, 1);
    chk("ms_offset_range", 32'(mso < SEC_MS), 1);
    fire(1'b0, 1'b1, 60);
    asb = 1'b1;
    fire(1'b0, 1'b1, 60);
    fire(1'b1, 1'b0, 60);
    tam = 1'b0;
    repeat (10) @(negedge clock);
    chk("all_reported", q_id.size(), 0);
    close_out();
  end
  initial
  begin
    repeat (40000) @(posedge clock);
    n_errors++;
    close_out();
  end
endmodule
bind ett_top ett_top_asserts #(.MS_CYCLES(MS_CYCLES)) chk_i (.clock(clock), .reset(reset),
  .capture_input_a(capture_input_a), .polarity_a(polarity_a), .time_alignment_mode(time_alignment_mode),
  .alignment_source_b(alignment_source_b), .outside_frequency_mode(outside_frequency_mode),
  .report_pop(report_pop), .report_valid(report_valid), .ref_out(ref_out), .oscillator_enable(oscillator_enable),
  .drift_from_outside(drift_from_outside), .second_pulse_out(second_pulse_out),
  .second_pulse_out_en_n(second_pulse_out_en_n), .module_ready(module_ready));
`default_nettype wire
